//--- hw/cms_pkg.sv
// Constants shared by the clock mode selector
//
// Contract
// - Reset leaves the main oscillator and the real-time oscillator both enabled.
// - After reset the low-frequency clock comes from the divided main clock.
// - After reset the multiplier is off and its select status bit reads 0.
// - The multiplied clock is the main clock times a factor held between two and twenty.
// - Exactly three modes exist, low-power, slow and operating, set by the select bits.
// - Real-time enabled, routed and low-frequency selected gives the real-time clock on both outputs, oscillator, multiplier and divider enables 0, real-time status 1.
// - Divided select outside low-power mode gives a core clock of main over two times (divider value plus one), multiplier off, slow mode.
// - All of low-frequency, divided and multiplier selects at 0 gives the plain main clock, multiplier off, slow mode.
// - Multiplier select alone enables the multiplier and gives its output, halved when the half bit is set, in operating mode.
// - Without the real-time route the low-frequency clock is the divided clock, divider on, real-time status 0.
// - Low-frequency select in low-power use also turns off the main oscillator and the multiplier.
package cms_pkg;
   localparam logic [15:0] CMS_ENABLE_KEY  = 16'h2305;
   localparam logic [15:0] CMS_DISABLE_KEY = 16'h1807;
   localparam int          CMS_KEY_LSB     = 16;
   localparam int          CMS_B_HALF      = 1;
   localparam int          CMS_B_PLLSEL    = 2;
   localparam int          CMS_B_LFSEL     = 3;
   localparam int          CMS_B_DIVSEL    = 5;
   localparam int          CMS_B_ROUTE     = 6;
   localparam int          CMS_B_RTEN      = 7;
   localparam int          CMS_B_MAINEN    = 8;
   localparam int          CMS_B_MULTEN    = 9;
   localparam int          CMS_B_DIVIDER_ENABLE     = 13;
   localparam int          CMS_B_RTSTAT    = 14;
   localparam logic [31:0] CMS_STATUS_RST  = 32'h0000_2180;
   localparam logic [7:0]  CMS_SEL_RST     = 8'h80;
   localparam logic [7:0]  CMS_SEL_MASK    = 8'hee;
   localparam logic [4:0]  CMS_MULT_MIN    = 5'h02;
   localparam logic [4:0]  CMS_MULT_MAX    = 5'h14;
   localparam logic [7:0]  CMS_HALF_M1     = 8'h01;
   typedef enum logic [1:0] {CMS_LOW_POWER, CMS_SLOW, CMS_OPERATING} cms_mode_t;
   typedef enum logic [1:0] {CMS_SRC_MAIN, CMS_SRC_DIV, CMS_SRC_MULT, CMS_SRC_RT} cms_src_t;
endpackage

//--- hw/cms_tick_div.sv
// Enable-pulse divider: one output pulse per (period_m1 + 1) input ticks
`timescale 1ns/100ps
`default_nettype none
module cms_tick_div
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic       tick,
   input  wire logic [7:0] period_m1,
   output logic            pulse
);
   logic [7:0] cnt_q;

   always_ff @(posedge mclk)
   begin
      if (!rst_n || !run)
         cnt_q <= 8'h00;
      else if (tick)
         cnt_q <= (cnt_q >= period_m1) ? 8'h00 : cnt_q + 8'h01;
   end

   // Compare with >= so a smaller period taken mid-count ends at once
   assign pulse = run && tick && (cnt_q >= period_m1);
endmodule
`default_nettype wire

//--- hw/cms_clock_mode_selector.sv
// Clock mode selector: keyed select bits, status, mode and clock enables
`timescale 1ns/100ps
`default_nettype none
module cms_clock_mode_selector
(
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire logic                enable_wr,
   input  wire logic                disable_wr,
   input  wire logic [31:0]         wr_data,
   input  wire logic [6:0]          divider_value,
   input  wire logic [4:0]          multiplier_req,
   input  wire logic                real_time_clock,
   input  wire logic                multiplied_clock,
   output logic      [31:0]         clock_status_reg,
   output cms_pkg::cms_mode_t       mode,
   output logic                     core_clock,
   output logic                     low_freq_clock,
   output logic                     divided_clock,
   output logic      [4:0]          multiplier_factor,
   output logic                     main_osc_enable,
   output logic                     multiplier_enable,
   output logic                     divider_enable,
   output logic                     rt_osc_enable
);
   import cms_pkg::*;

   // ----------------------------------------------------------------
   // Keyed select register
   // ----------------------------------------------------------------
   logic [7:0] sel_q;
   logic       en_ok;
   logic       dis_ok;

   assign en_ok  = enable_wr  && (wr_data[CMS_KEY_LSB +: 16] == CMS_ENABLE_KEY);
   assign dis_ok = disable_wr && (wr_data[CMS_KEY_LSB +: 16] == CMS_DISABLE_KEY);

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         sel_q <= CMS_SEL_RST;
      // Bits 0 and 4 hold nothing and must read 0 in status
      else if (en_ok || dis_ok)
         sel_q <= (sel_q | (en_ok ? (wr_data[7:0] & CMS_SEL_MASK) : 8'h00))
                  & ~(dis_ok ? (wr_data[7:0] & CMS_SEL_MASK) : 8'h00);
   end

   logic rt_en;
   logic route;
   logic lf_sel;
   logic div_sel;
   logic pll_sel;
   logic half_sel;
   assign rt_en    = sel_q[CMS_B_RTEN];
   assign route    = sel_q[CMS_B_ROUTE];
   assign lf_sel   = sel_q[CMS_B_LFSEL];
   assign div_sel  = sel_q[CMS_B_DIVSEL];
   assign pll_sel  = sel_q[CMS_B_PLLSEL];
   assign half_sel = sel_q[CMS_B_HALF];

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   logic     rt_lf;
   logic     low_power_mode;
   logic     use_mult;
   cms_src_t want_src;
   cms_src_t src_q;

   assign rt_lf    = rt_en && route;
   assign low_power_mode      = rt_lf && lf_sel;
   assign use_mult = !low_power_mode && !lf_sel && !div_sel && pll_sel;

   always_comb
   begin
      if (low_power_mode)
         want_src = CMS_SRC_RT;
      else if (div_sel || lf_sel)
         want_src = CMS_SRC_DIV;
      else if (pll_sel)
         want_src = CMS_SRC_MULT;
      else
         want_src = CMS_SRC_MAIN;
   end

   always_comb
   begin
      if (low_power_mode)
         mode = CMS_LOW_POWER;
      else if (use_mult)
         mode = CMS_OPERATING;
      else
         mode = CMS_SLOW;
   end

   // Enables follow the active source too, so a source being left keeps
   // running until the switch point has been reached
   assign main_osc_enable   = !low_power_mode || (src_q != CMS_SRC_RT);
   assign multiplier_enable = use_mult || (src_q == CMS_SRC_MULT);
   assign divider_enable    = !rt_lf || (!low_power_mode && div_sel)
                              || (src_q == CMS_SRC_DIV);
   assign rt_osc_enable     = rt_en || (src_q == CMS_SRC_RT);

   always_comb
   begin
      clock_status_reg               = 32'h0000_0000;
      clock_status_reg[7:1]          = sel_q[7:1];
      clock_status_reg[CMS_B_MAINEN] = !low_power_mode;
      clock_status_reg[CMS_B_MULTEN] = use_mult;
      clock_status_reg[CMS_B_DIVIDER_ENABLE]  = !rt_lf || (!low_power_mode && div_sel);
      clock_status_reg[CMS_B_RTSTAT] = rt_lf;
   end

   // ----------------------------------------------------------------
   // Multiplier factor
   // ----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         multiplier_factor <= CMS_MULT_MIN;
      else if (multiplier_req < CMS_MULT_MIN)
         multiplier_factor <= CMS_MULT_MIN;
      else if (multiplier_req > CMS_MULT_MAX)
         multiplier_factor <= CMS_MULT_MAX;
      else
         multiplier_factor <= multiplier_req;
   end

   // ----------------------------------------------------------------
   // Pin synchronisers and edge ticks
   // ----------------------------------------------------------------
   logic [2:0] rt_sync_q;
   logic [2:0] mul_sync_q;
   logic       rt_tick;
   logic       mul_tick;

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         rt_sync_q <= 3'h0;
      else
         rt_sync_q <= {rt_sync_q[1:0], real_time_clock};
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         mul_sync_q <= 3'h0;
      else
         mul_sync_q <= {mul_sync_q[1:0], multiplied_clock};
   end

   // Only stages 1 and 2 feed the edge detectors
   assign rt_tick  = rt_osc_enable && rt_sync_q[1] && !rt_sync_q[2];
   assign mul_tick = multiplier_enable && mul_sync_q[1] && !mul_sync_q[2];

   // ----------------------------------------------------------------
   // Dividers
   // ----------------------------------------------------------------
   logic [7:0] div_m1;
   logic       div_pulse;
   logic       half_pulse;

   assign div_m1 = {divider_value, 1'b1};

   cms_tick_div u_main_div
   (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .run       (divider_enable),
      .tick      (1'b1),
      .period_m1 (div_m1),
      .pulse     (div_pulse)
   );

   cms_tick_div u_half_div
   (
      .mclk      (mclk),
      .rst_n     (rst_n),
      .run       (multiplier_enable),
      .tick      (mul_tick),
      .period_m1 (CMS_HALF_M1),
      .pulse     (half_pulse)
   );

   // ----------------------------------------------------------------
   // Core source switch and clock enables
   // ----------------------------------------------------------------
   logic src_pulse;
   logic mult_pulse;

   assign mult_pulse = half_sel ? half_pulse : mul_tick;

   always_comb
   begin
      case (src_q)
         CMS_SRC_MAIN: src_pulse = 1'b1;
         CMS_SRC_DIV:  src_pulse = div_pulse;
         CMS_SRC_MULT: src_pulse = mult_pulse;
         default:      src_pulse = rt_tick;
      endcase
   end

   // Switch only on the old source's period end, trading a short latency
   // for no runt period at the change
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         src_q <= CMS_SRC_MAIN;
      else if (src_pulse && (want_src != src_q))
         src_q <= want_src;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         core_clock     <= 1'b0;
         low_freq_clock <= 1'b0;
         divided_clock  <= 1'b0;
      end
      else
      begin
         core_clock     <= src_pulse;
         low_freq_clock <= rt_lf ? rt_tick : div_pulse;
         divided_clock  <= div_pulse;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_reset_status: assert property ($rose(rst_n) |-> clock_status_reg == CMS_STATUS_RST)
      else $error("status wrong after reset");
   a_osc_on_reset: assert property ($rose(rst_n) |-> main_osc_enable && rt_osc_enable)
      else $error("oscillators not on after reset");
   a_lf_after_reset: assert property ($rose(rst_n) |-> !clock_status_reg[CMS_B_RTSTAT])
      else $error("low-frequency source wrong after reset");
   a_bad_enable_key: assert property (enable_wr && !disable_wr
         && wr_data[31:16] != CMS_ENABLE_KEY |=> $stable(clock_status_reg[7:1]))
      else $error("enable write without key took effect");
   a_bad_disable_key: assert property (disable_wr && !enable_wr
         && wr_data[31:16] != CMS_DISABLE_KEY |=> $stable(clock_status_reg[7:1]))
      else $error("disable write without key took effect");
   a_key_set_bit: assert property (enable_wr && !disable_wr
         && wr_data[31:16] == CMS_ENABLE_KEY && wr_data[CMS_B_DIVSEL]
         |=> clock_status_reg[CMS_B_DIVSEL])
      else $error("keyed set not shown in status");
   a_lpm_status: assert property (mode == CMS_LOW_POWER |-> clock_status_reg[14:8]
         == 7'h40)
      else $error("low-power status bits wrong");
   a_lpm_osc_off: assert property (mode == CMS_LOW_POWER && src_q == CMS_SRC_RT
         |-> !main_osc_enable && !multiplier_enable)
      else $error("oscillator or multiplier left on in low-power");
   a_oper_mode: assert property (mode == CMS_OPERATING
         |-> clock_status_reg[CMS_B_MULTEN]
         && !clock_status_reg[CMS_B_DIVSEL] && !clock_status_reg[CMS_B_LFSEL])
      else $error("operating mode without multiplier");
   a_slow_no_mult: assert property (mode == CMS_SLOW |-> !clock_status_reg[CMS_B_MULTEN])
      else $error("multiplier on in slow mode");
   a_main_every: assert property (src_q == CMS_SRC_MAIN |=> core_clock)
      else $error("main source not every cycle");
   a_factor_range: assert property (multiplier_factor >= CMS_MULT_MIN
         && multiplier_factor <= CMS_MULT_MAX)
      else $error("multiplier factor out of range");
   // The first pulse after entry may follow the old source's last one at once
   a_div_spacing: assert property (src_q == CMS_SRC_DIV && $past(src_q) == CMS_SRC_DIV
         && divider_value == 7'h00 && $stable(divider_value) && core_clock
         |=> !core_clock ##1 core_clock)
      else $error("divided core period wrong");
   a_no_runt: assert property (src_q != $past(src_q) |-> core_clock)
      else $error("source changed off a period end");
   a_lf_div: assert property (!rt_lf |=> low_freq_clock == $past(div_pulse))
      else $error("low-frequency clock not divided clock");

   c_enter_lpm:  cover property (mode == CMS_LOW_POWER ##1 src_q == CMS_SRC_RT);
   c_enter_oper: cover property (mode == CMS_OPERATING ##[1:20] src_q == CMS_SRC_MULT);
   c_enter_div:  cover property (src_q == CMS_SRC_DIV ##[1:20] core_clock);
   c_key_write:  cover property (en_ok ##1 dis_ok);
endmodule
`default_nettype wire

//--- tb/cms_clock_mode_selector_tb.sv
// Self-checking testbench of the clock mode selector
`timescale 1ns/100ps
`default_nettype none
module cms_clock_mode_selector_tb;
   import cms_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        mclk;
   logic        rst_n;
   logic        enable_wr;
   logic        disable_wr;
   logic [31:0] wr_data;
   logic [6:0]  divider_value;
   logic [4:0]  multiplier_req;
   logic        real_time_clock;
   logic        multiplied_clock;
   logic [31:0] clock_status_reg;
   cms_mode_t   mode;
   logic        core_clock;
   logic        low_freq_clock;
   logic        divided_clock;
   logic [4:0]  multiplier_factor;
   logic        main_osc_enable;
   logic        multiplier_enable;
   logic        divider_enable;
   logic        rt_osc_enable;
   logic [7:0]  sel_q;
   logic [31:0] rnd;
   logic [31:0] st;
   int          errors = 0;
   int          checked = 0;
   int          cycles = 0;
   int          ph = 0;
   int          g;
   int          dv;

   cms_clock_mode_selector cms_clock_mode_selector_inst
   (
      .mclk              (mclk),
      .rst_n             (rst_n),
      .enable_wr         (enable_wr),
      .disable_wr        (disable_wr),
      .wr_data           (wr_data),
      .divider_value     (divider_value),
      .multiplier_req    (multiplier_req),
      .real_time_clock   (real_time_clock),
      .multiplied_clock  (multiplied_clock),
      .clock_status_reg  (clock_status_reg),
      .mode              (mode),
      .core_clock        (core_clock),
      .low_freq_clock    (low_freq_clock),
      .divided_clock     (divided_clock),
      .multiplier_factor (multiplier_factor),
      .main_osc_enable   (main_osc_enable),
      .multiplier_enable (multiplier_enable),
      .divider_enable    (divider_enable),
      .rt_osc_enable     (rt_osc_enable)
   );

   // ------------------------------------------------------------
   // Clock, pins and watchdog
   // ------------------------------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Pin periods: multiplier 8 cycles, real-time 12 cycles
   always
   begin
      @(posedge mclk);
      #1;
      ph = ph + 1;
      if (ph % 4 == 0) multiplied_clock = ~multiplied_clock;
      if (ph % 6 == 0) real_time_clock = ~real_time_clock;
   end

   always @(posedge mclk)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         errors = errors + 1;
         final_report();
      end
   end

   // ------------------------------------------------------------
   // Expectations
   // ------------------------------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [31:0] exp_status(input logic [7:0] s);
      logic        rs;
      logic [31:0] v;
      rs = s[CMS_B_RTEN] & s[CMS_B_ROUTE];
      v = {24'h0, s & 8'hee};
      v[CMS_B_MAINEN] = ~(rs & s[CMS_B_LFSEL]);
      v[CMS_B_MULTEN] = s[CMS_B_PLLSEL] & ~s[CMS_B_LFSEL] & ~s[CMS_B_DIVSEL];
      v[CMS_B_DIVIDER_ENABLE] = ~rs | (~s[CMS_B_LFSEL] & s[CMS_B_DIVSEL]);
      v[CMS_B_RTSTAT] = rs;
      return v;
   endfunction

   function automatic logic [1:0] exp_mode(input logic [31:0] v);
      if (!v[CMS_B_MAINEN]) return 2'h0;
      return v[CMS_B_MULTEN] ? 2'h2 : 2'h1;
   endfunction

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked = checked + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic cmp_gap(input int got, input int exp, input string what);
      checked = checked + 1;
      if (got != exp)
      begin
         errors = errors + 1;
         $display("Error %0t: %s gap %0d exp %0d", $time, what, got, exp);
      end
   endtask

   // Strobes stay up so writes may follow back to back
   task automatic wr(input logic en, input logic dis, input logic [31:0] d);
      enable_wr = en;
      disable_wr = dis;
      wr_data = d;
      @(posedge mclk);
      #1;
      if (en && d[31:16] == CMS_ENABLE_KEY) sel_q = sel_q | (d[7:0] & 8'hee);
      if (dis && d[31:16] == CMS_DISABLE_KEY) sel_q = sel_q & ~(d[7:0] & 8'hee);
      st = exp_status(sel_q);
      cmp_val(clock_status_reg, st, "status");
      cmp_val({30'h0, mode}, {30'h0, exp_mode(st)}, "mode");
   endtask

   task automatic idle();
      enable_wr = 1'b0;
      disable_wr = 1'b0;
   endtask

   // First pass only finds a pulse, the last gap is taken after settling
   task automatic meas(input int which, output int gap);
      int n;
      gap = 0;
      for (int k = 0; k < 3; k++)
      begin
         n = 0;
         do
         begin
            @(posedge mclk);
            #1;
            n = n + 1;
         end
         while (((which == 0) ? core_clock : (which == 1) ? low_freq_clock : divided_clock)
                !== 1'b1 && n < 100);
         gap = n;
      end
   endtask

   task automatic run_case(input logic [7:0] s, input int core_exp, input int lf_exp);
      wr(1'b0, 1'b1, {CMS_DISABLE_KEY, 16'h00ff});
      wr(1'b1, 1'b0, {CMS_ENABLE_KEY, 8'h00, s});
      idle();
      meas(1'b0, g);
      cmp_gap(g, core_exp, "core");
      meas(1'b1, g);
      cmp_gap(g, lf_exp, "lowfreq");
      cmp_val({28'h0, main_osc_enable, multiplier_enable, divider_enable, rt_osc_enable},
              {28'h0, st[8], st[9], st[13], st[7]}, "enables");
   endtask

   task automatic final_report();
      if (errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      enable_wr = 1'b0;
      disable_wr = 1'b0;
      wr_data = 32'h0;
      divider_value = 7'h01;
      multiplier_req = 5'h02;
      real_time_clock = 1'b0;
      multiplied_clock = 1'b0;
      sel_q = CMS_SEL_RST;
      rnd = 32'h15;
      repeat (6) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      cmp_val(clock_status_reg, CMS_STATUS_RST, "reset status");
      cmp_val({30'h0, mode}, 32'h1, "reset mode");
      meas(1'b1, g);
      cmp_gap(g, 4, "reset lowfreq");
      meas(2, g);
      cmp_gap(g, 4, "reset divided");
      // Random keyed writes, wrong keys among them
      for (int i = 0; i < 300; i++)
      begin
         rnd = xorshift(rnd);
         wr(rnd[0], rnd[1], {(rnd[3:2] == 2'h0) ? rnd[31:16] :
            (rnd[0] ? CMS_ENABLE_KEY : CMS_DISABLE_KEY), 8'h00, rnd[15:8]});
      end
      idle();
      // Factor clamp over every request value
      for (int i = 0; i < 32; i++)
      begin
         multiplier_req = 5'(i);
         repeat (2) @(posedge mclk);
         #1;
         cmp_val({27'h0, multiplier_factor}, (i < 2) ? 32'h2 : (i > 20) ? 32'h14 : 32'(i),
                 "factor");
      end
      for (int j = 0; j < 2; j++)
      begin
         rnd = xorshift(rnd);
         dv = (j == 0) ? 0 : int'(rnd[2:0]) + 1;
         divider_value = 7'(dv);
         run_case(8'h00, 1, 2 * (dv + 1));
         meas(2, g);
         cmp_gap(g, 2 * (dv + 1), "divided");
         run_case(8'h20, 2 * (dv + 1), 2 * (dv + 1));
         run_case(8'h08, 2 * (dv + 1), 2 * (dv + 1));
         run_case(8'h04, 8, 2 * (dv + 1));
         run_case(8'h06, 16, 2 * (dv + 1));
         run_case(8'hc8, 12, 12);
         run_case(8'hc0, 1, 12);
         run_case(8'hc4, 8, 12);
      end
      final_report();
   end
endmodule
`default_nettype wire
